// ### src/qrc_pkg.sv
// Package: timing constants and states for the quasi-resonant cycle control
package qrc_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int MIN_PERIOD_NS = 8000;
   localparam int BLANK_NS = 3000;
   localparam int MAX_ON_NS = 50000;
   localparam int TIMEOUT_NS = 8000;
   localparam int RESTART_HOLD_NS = 100000;
   localparam int NS_PER_S = 1_000_000_000;
   localparam int CLK_NS = NS_PER_S / CLK_HZ;
   // Least times round up, longest times round down
   localparam int MIN_PERIOD_CYC = (MIN_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
   localparam int MAX_ON_CYC = MAX_ON_NS / CLK_NS;
   localparam int TIMEOUT_CYC = (TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int RESTART_HOLD_CYC = RESTART_HOLD_NS / CLK_NS;
   localparam int SS_STEPS = 255;
   localparam int CNT_W = 16;
   localparam int SS_W = 8;
   typedef enum logic [1:0] {
      QRC_RUN,
      QRC_RESTART,
      QRC_LATCH
   } qrc_mode_t;
endpackage : qrc_pkg

// ### src/qrc_cycle_ctrl.sv
// Cycle-by-cycle gate drive control for a quasi-resonant flyback stage
`timescale 1ns/100ps
module qrc_cycle_ctrl #(
   parameter int MIN_PERIOD_CYC = qrc_pkg::MIN_PERIOD_CYC,
   parameter int BLANK_CYC = qrc_pkg::BLANK_CYC,
   parameter int MAX_ON_CYC = qrc_pkg::MAX_ON_CYC,
   parameter int TIMEOUT_CYC = qrc_pkg::TIMEOUT_CYC,
   parameter int RESTART_HOLD_CYC = qrc_pkg::RESTART_HOLD_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic peak_trip,
   input wire logic demag_cmp,
   input wire logic skip_req,
   input wire logic uv_cmp,
   input wire logic below_4v,
   input wire logic fault_timer_run,
   input wire logic fault_latch_req,
   output logic gate_drive_out,
   output logic restart_mode,
   output logic latched,
   output logic [qrc_pkg::SS_W-1:0] soft_start_level
);
   localparam int W = qrc_pkg::CNT_W;
   localparam int NSYNC = 7;
   localparam int SSW = qrc_pkg::SS_W;

   // Two-stage synchronisers, one per asynchronous input, all seven
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] s1_r;
   logic [NSYNC-1:0] s2_r;
   assign async_in = {fault_latch_req, fault_timer_run, below_4v, uv_cmp,
                      skip_req, demag_cmp, peak_trip};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               s1_r[gi] <= 1'b0;
               s2_r[gi] <= 1'b0;
            end else begin
               s1_r[gi] <= async_in[gi];
               s2_r[gi] <= s1_r[gi];
            end
         end
      end
   endgenerate

   logic peak_s, demag_s, skip_s, uv_s, b4_s, ftr_s, flr_s;
   assign {flr_s, ftr_s, b4_s, uv_s, skip_s, demag_s, peak_s} = s2_r;

   logic gate_r, gate_nxt;
   logic demag_d_r, demag_d_nxt;
   logic skip_d_r, skip_d_nxt;
   logic [W-1:0] per_r, per_nxt;
   logic [W-1:0] blank_r, blank_nxt;
   logic [W-1:0] on_r, on_nxt;
   logic [W-1:0] to_r, to_nxt;
   logic [W-1:0] hold_r, hold_nxt;
   logic [qrc_pkg::SS_W-1:0] ss_r, ss_nxt;
   qrc_pkg::qrc_mode_t mode_r, mode_nxt;

   logic demag_rise, timeout_done, period_done, blank_done, set_ev;
   logic stop, too_long;
   logic set_ok;
   assign demag_rise = demag_s && !demag_d_r;
   assign period_done = (per_r == '0);
   assign blank_done = (blank_r == '0);
   assign timeout_done = (to_r == '0);
   // Timeout expiry stands in for a demag edge once ringing has died;
   // if skip holds the drive then, its release restarts instead
   assign set_ev = demag_rise || (to_r == W'(1))
                   || (timeout_done && !skip_s && skip_d_r);
   assign too_long = gate_r && (on_r == W'(MAX_ON_CYC - 1));
   assign stop = uv_s || (mode_r != qrc_pkg::QRC_RUN);
   assign set_ok = !stop && !skip_s && set_ev && period_done && blank_done;

   always_comb begin
      gate_nxt = gate_r;
      per_nxt = (per_r != '0) ? per_r - W'(1) : per_r;
      blank_nxt = (blank_r != '0) ? blank_r - W'(1) : blank_r;
      on_nxt = gate_r ? on_r + W'(1) : '0;
      to_nxt = (to_r != '0) ? to_r - W'(1) : to_r;
      hold_nxt = (hold_r != '0) ? hold_r - W'(1) : hold_r;
      ss_nxt = (ss_r != '1) ? ss_r + SSW'(1) : ss_r;
      mode_nxt = mode_r;
      demag_d_nxt = demag_s;
      skip_d_nxt = skip_s;
      if (demag_rise) begin
         to_nxt = W'(TIMEOUT_CYC);
      end
      if (!skip_s && skip_d_r) begin
         ss_nxt = '0;
      end
      if (gate_r) begin
         if (peak_s || stop || skip_s || too_long) begin
            gate_nxt = 1'b0;
            blank_nxt = W'(BLANK_CYC);
         end
      end else if (set_ok) begin
         gate_nxt = 1'b1;
         per_nxt = W'(MIN_PERIOD_CYC - 1);
      end
      unique case (mode_r)
         qrc_pkg::QRC_RUN: begin
            if (too_long) begin
               mode_nxt = qrc_pkg::QRC_RESTART;
               hold_nxt = W'(RESTART_HOLD_CYC);
            end
            if (flr_s || (uv_s && ftr_s)) begin
               mode_nxt = qrc_pkg::QRC_LATCH;
            end
         end
         qrc_pkg::QRC_RESTART: begin
            if (hold_r == '0 && !uv_s) begin
               mode_nxt = qrc_pkg::QRC_RUN;
               ss_nxt = '0;
            end
         end
         qrc_pkg::QRC_LATCH: begin
            if (b4_s) begin
               mode_nxt = qrc_pkg::QRC_RUN;
               ss_nxt = '0;
            end
         end
         default: mode_nxt = qrc_pkg::QRC_LATCH;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gate_r <= 1'b0;
         per_r <= '0;
         blank_r <= '0;
         on_r <= '0;
         to_r <= '0;
         hold_r <= '0;
         ss_r <= '0;
         mode_r <= qrc_pkg::QRC_RUN;
         demag_d_r <= 1'b0;
         skip_d_r <= 1'b0;
      end else begin
         gate_r <= gate_nxt;
         per_r <= per_nxt;
         blank_r <= blank_nxt;
         on_r <= on_nxt;
         to_r <= to_nxt;
         hold_r <= hold_nxt;
         ss_r <= ss_nxt;
         mode_r <= mode_nxt;
         demag_d_r <= demag_d_nxt;
         skip_d_r <= skip_d_nxt;
      end
   end

   assign gate_drive_out = gate_r;
   assign restart_mode = (mode_r == qrc_pkg::QRC_RESTART);
   assign latched = (mode_r == qrc_pkg::QRC_LATCH);
   assign soft_start_level = ss_r;

   // Watch counters kept apart from the timers they check; they saturate
   // so a long idle spell never wraps into a false short gap
   logic [W-1:0] gap_r, gap_nxt;
   logic [W-1:0] low_r, low_nxt;

   always_comb begin
      gap_nxt = (gap_r != '1) ? gap_r + W'(1) : gap_r;
      low_nxt = (low_r != '1) ? low_r + W'(1) : low_r;
      if (gate_nxt && !gate_r) begin
         gap_nxt = '0;
      end
      if (gate_r && !gate_nxt) begin
         low_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         gap_r <= '1;
         low_r <= '1;
      end else begin
         gap_r <= gap_nxt;
         low_r <= low_nxt;
      end
   end

   property p_period;
      @(posedge clk) disable iff (!rst_b)
      (gate_nxt && !gate_r) |-> (gap_r >= W'(MIN_PERIOD_CYC - 1));
   endproperty
   a_period: assert property (p_period)
      else $error("gate restarted early");

   property p_peak;
      @(posedge clk) disable iff (!rst_b)
      (gate_r && peak_s) |=> !gate_r;
   endproperty
   a_peak: assert property (p_peak) else $error("peak trip ignored");

   property p_maxon;
      @(posedge clk) disable iff (!rst_b)
      too_long |=> !gate_r && (restart_mode || latched);
   endproperty
   a_maxon: assert property (p_maxon)
      else $error("max on not enforced");

   property p_blank;
      @(posedge clk) disable iff (!rst_b)
      (gate_nxt && !gate_r) |-> (low_r >= W'(BLANK_CYC));
   endproperty
   a_blank: assert property (p_blank)
      else $error("restart in blanking");

   property p_set_cause;
      @(posedge clk) disable iff (!rst_b)
      $rose(gate_r) |-> $past(set_ev) && $past(period_done);
   endproperty
   a_set_cause: assert property (p_set_cause)
      else $error("set w/o cause");

   property p_skip;
      @(posedge clk) disable iff (!rst_b)
      skip_s |=> !$rose(gate_r);
   endproperty
   a_skip: assert property (p_skip) else $error("set during skip");

   property p_uv;
      @(posedge clk) disable iff (!rst_b)
      uv_s |=> !gate_r;
   endproperty
   a_uv: assert property (p_uv) else $error("uv did not stop");

   property p_latch;
      @(posedge clk) disable iff (!rst_b)
      (mode_r == qrc_pkg::QRC_RUN && uv_s && ftr_s) |=> latched;
   endproperty
   a_latch: assert property (p_latch) else $error("no latch-off");

   property p_latch_hold;
      @(posedge clk) disable iff (!rst_b)
      (latched && !b4_s) |=> latched && !gate_r;
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latch lost");

   property p_ss;
      @(posedge clk) disable iff (!rst_b)
      (!skip_s && skip_d_r) |=> (ss_r == '0);
   endproperty
   a_ss: assert property (p_ss) else $error("soft start not rearmed");
endmodule : qrc_cycle_ctrl

// ### dv/qrc_stage_model.sv
// Power stage model: peak comparator and demag ringing
`timescale 1ns/100ps
module qrc_stage_model #(
   parameter int ON_CYC = 10,
   parameter int RING_CYC = 15
) (
   input wire logic clk,
   input wire logic en,
   input wire logic gate,
   output logic peak_trip,
   output logic demag_cmp
);
   int on_cnt = 0;
   int off_cnt = 0;
   // Rings repeat each RING_CYC while off, so early edges get a valley
   always @(negedge clk) begin
      on_cnt <= gate ? on_cnt + 1 : 0;
      off_cnt <= gate ? 0 : off_cnt + 1;
      peak_trip <= en && gate && on_cnt >= ON_CYC;
      demag_cmp <= en && !gate && off_cnt % RING_CYC >= RING_CYC - 2;
   end
endmodule : qrc_stage_model

// ### dv/test_quasi_resonant_cycle_control.sv
// Testbench for the quasi-resonant cycle control block
`timescale 1ns/100ps
module test_quasi_resonant_cycle_control;
   localparam int MINP = 40;
   localparam int MAXON = 60;
   localparam int TMO = 40;
   localparam int HOLD = 50;
   localparam int ON = 10;
   localparam int RING = 15;
   logic clk, rst_b, peak_trip, demag_cmp, skip_req, uv_cmp, below_4v;
   logic fault_timer_run, fault_latch_req, en;
   logic gate_drive_out, restart_mode, latched;
   logic [qrc_pkg::SS_W-1:0] soft_start_level;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   qrc_stage_model #(.ON_CYC(ON), .RING_CYC(RING)) stage (.clk(clk),
      .en(en), .gate(gate_drive_out), .peak_trip(peak_trip),
      .demag_cmp(demag_cmp));
   qrc_cycle_ctrl #(.MIN_PERIOD_CYC(MINP), .BLANK_CYC(10),
      .MAX_ON_CYC(MAXON), .TIMEOUT_CYC(TMO), .RESTART_HOLD_CYC(HOLD)) dut (
      .clk(clk), .rst_b(rst_b), .peak_trip(peak_trip),
      .demag_cmp(demag_cmp), .skip_req(skip_req), .uv_cmp(uv_cmp),
      .below_4v(below_4v), .fault_timer_run(fault_timer_run),
      .fault_latch_req(fault_latch_req), .gate_drive_out(gate_drive_out),
      .restart_mode(restart_mode), .latched(latched),
      .soft_start_level(soft_start_level));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic wrap_up();
      if (fail_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // Ceiling well above the thousand or so cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         $display("wrong value at %0t: run timed out", $time);
         wrap_up();
      end
   end
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic wait_gate(input logic lvl, input int lim, output int n);
      n = 0;
      while (gate_drive_out !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_gate
   task automatic t_cycle();
      int n1, n2;
      en = 1'b1;
      wait_gate(1'b1, 200, n1);
      wait_gate(1'b0, 200, n1);
      wait_gate(1'b1, 200, n2);
      wait_gate(1'b0, 200, n1);
      chk(n1 >= ON && n1 <= ON + 6, "peak trip on-time");
      wait_gate(1'b1, 200, n2);
      chk(n1 + n2 >= MINP, "period below minimum");
      chk(n1 + n2 <= MINP + RING + 6, "missed next valley");
   endtask : t_cycle
   task automatic t_max_on();
      int n;
      wait_gate(1'b0, 200, n);
      en = 1'b0;
      wait_gate(1'b1, TMO + 20, n);
      chk(gate_drive_out === 1'b1, "no timeout restart");
      wait_gate(1'b0, MAXON + 10, n);
      chk(n >= MAXON - 1 && n <= MAXON + 1, "max on-time");
      repeat (2) @(negedge clk);
      chk(restart_mode === 1'b1, "restart hold");
      en = 1'b1;
      wait_gate(1'b1, HOLD - 8, n);
      chk(gate_drive_out === 1'b0, "pulse in restart hold");
   endtask : t_max_on
   task automatic t_skip();
      int n;
      skip_req = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 150; i++) begin
         @(negedge clk);
         chk(gate_drive_out === 1'b0, "gate during skip");
      end
      skip_req = 1'b0;
      repeat (4) @(negedge clk);
      chk(soft_start_level <= 8'h08, "soft start not rearmed");
      wait_gate(1'b1, RING + 10, n);
      chk(gate_drive_out === 1'b1, "no restart after skip");
      uv_cmp = 1'b1;
      repeat (5) @(negedge clk);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         chk(gate_drive_out === 1'b0, "gate during undervoltage");
      end
      uv_cmp = 1'b0;
      repeat (60) @(negedge clk);
   endtask : t_skip
   // Pass 0 external latch request, pass 1 undervoltage with timer
   task automatic t_latch();
      for (int k = 0; k < 2; k++) begin
         fault_timer_run = k[0];
         uv_cmp = k[0];
         fault_latch_req = !k[0];
         repeat (5) @(negedge clk);
         chk(latched === 1'b1 && gate_drive_out === 1'b0, "entry");
         {uv_cmp, fault_latch_req, fault_timer_run} = '0;
         repeat (100) @(negedge clk);
         chk(latched === 1'b1 && gate_drive_out === 1'b0, "hold");
         below_4v = 1'b1;
         repeat (5) @(negedge clk);
         chk(latched === 1'b0, "latch not cleared");
         below_4v = 1'b0;
         repeat (60) @(negedge clk);
      end
   endtask : t_latch
   initial begin
      {rst_b, skip_req, uv_cmp, below_4v, fault_timer_run} = '0;
      fault_latch_req = 1'b0;
      en = 1'b0;
      repeat (12) @(negedge clk);
      chk(gate_drive_out === 1'b0, "gate in reset");
      rst_b = 1'b1;
      t_cycle();
      t_max_on();
      t_skip();
      t_latch();
      wrap_up();
   end
endmodule : test_quasi_resonant_cycle_control
